// ==== src/flash_seq_pkg.sv ====
package flash_seq_pkg;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'haaa;
  localparam logic [2:0] QUERY_ID = 3'h1;
  localparam logic [2:0] QUERY_PROT = 3'h2;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO = 8'h00;
  localparam logic [7:0] ALL_SECTORS = 8'hff;
  localparam logic [7:0] NO_SECTORS = 8'h00;
  localparam int CLK_MHZ = 100;
  localparam int ERASE_GAP_US = 80;
  localparam int ERASE_GAP_CYC = ERASE_GAP_US * CLK_MHZ;
  localparam int TMO_W = 16;
  // Arbitrary neutral identification value
  localparam logic [7:0] DEVICE_ID = 8'h5a;
  typedef enum logic [3:0] {
    ST_READ = 4'h0,
    ST_UNL1 = 4'h1,
    ST_UNL2 = 4'h2,
    ST_PROG_DATA = 4'h3,
    ST_ERA_SETUP = 4'h4,
    ST_ERA_UNL1 = 4'h5,
    ST_ERA_UNL2 = 4'h6,
    ST_ERA_ACCUM = 4'h7,
    ST_QUERY = 4'h8,
    ST_SUSPENDED = 4'h9
  } dec_state_t;
endpackage : flash_seq_pkg

// ==== src/flash_bus_if.sv ====
`timescale 1ns/1ps
interface flash_bus_if;
  logic [17:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr_n;
  logic rd_n;
  logic [7:0] sector_selects;
  logic ready_busy_pin;
  logic error_flag_bit;
  modport device (input addr, wdata, wr_n, rd_n, sector_selects, output rdata, ready_busy_pin, error_flag_bit);
  modport host (output addr, wdata, wr_n, rd_n, sector_selects, input rdata, ready_busy_pin, error_flag_bit);
endinterface : flash_bus_if

// ==== src/flash_instruction_sequence_decoder.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Sequences open with AA@555, 55@AAA
// - Decode only address bits eleven to zero
// - Each write cycle needs exactly one sector select
// - 90h then read A6,A1,A0=001 gives identifier
// - Query 010 returns sector protection 01/00
// - A0h then data write starts programming
// - 80h, unlock, 10h erases all sectors
// - 30h per sector within 80 us
// - B0h suspends only running sector erase
// - 30h resumes only when erase suspended
// - F0h returns to read array mode
// - Bad byte or time-out aborts to read
// - Sequence bytes decoded, never stored
// - Read array after reset and reset command
// - Address at write fall, data at rise
// - Host runs single bus cycles on user request
// - Protection also readable as read-only register
// - Ready/busy low while program or erase, held high while erase suspended
// - Program to protected sector ignored
module flash_instruction_sequence_decoder #(
  parameter int TMO_CYC = flash_seq_pkg::ERASE_GAP_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Processor bus
  flash_bus_if.device BUS,
  // Array and algorithm side
  input wire logic [7:0] PROTECT,
  input wire logic [7:0] ARRAY_DATA,
  input wire logic ALGO_BUSY,
  input wire logic ALGO_ERROR,
  output logic PROG_START,
  output logic [17:0] PROG_ADDR,
  output logic [7:0] PROG_DATA,
  output logic ERASE_START,
  output logic [7:0] ERASE_SECTORS,
  output logic ERASE_SUSPEND,
  output logic ERASE_RESUME,
  output logic [7:0] PROT_REG
);
  // Three-stage sampler on the write strobe
  logic [2:0] wr_sync;
  logic wr_level;
  logic wr_fall;
  logic wr_rise;
  logic [17:0] lat_addr;
  logic [7:0] lat_sel;
  flash_seq_pkg::dec_state_t state;
  flash_seq_pkg::dec_state_t next_state;
  logic [flash_seq_pkg::TMO_W-1:0] tmo_cnt;
  logic erasing;
  logic suspended;
  logic err;
  logic [7:0] erase_acc;
  logic [7:0] rdata;

  assign wr_fall = wr_level & ~wr_sync[2] & ~wr_sync[1];
  assign wr_rise = ~wr_level & wr_sync[2] & wr_sync[1];

  wire [11:0] low_addr = lat_addr[11:0];
  wire [7:0] d = BUS.wdata;
  wire one_sel = (lat_sel != flash_seq_pkg::NO_SECTORS) && ((lat_sel & (lat_sel - 8'h01)) == 8'h00);
  wire is_unl1 = one_sel && d == flash_seq_pkg::CMD_UNLOCK1 && low_addr == flash_seq_pkg::ADDR_UNLOCK1;
  wire is_unl2 = one_sel && d == flash_seq_pkg::CMD_UNLOCK2 && low_addr == flash_seq_pkg::ADDR_UNLOCK2;
  wire at_555 = one_sel && low_addr == flash_seq_pkg::ADDR_UNLOCK1;
  // Suspend only counts while a sector erase really runs
  wire suspend_ok = one_sel && d == flash_seq_pkg::CMD_SUSPEND && erasing && !suspended;
  wire sel_prot = |(lat_sel & PROTECT);
  wire timed_out = tmo_cnt >= flash_seq_pkg::TMO_W'(TMO_CYC);
  wire in_seq = state != flash_seq_pkg::ST_READ && state != flash_seq_pkg::ST_QUERY
    && state != flash_seq_pkg::ST_SUSPENDED;
  wire [2:0] qsel = {BUS.addr[6], BUS.addr[1], BUS.addr[0]};
  wire rd_sel = BUS.sector_selects != flash_seq_pkg::NO_SECTORS;
  wire [7:0] prot_byte = (|(BUS.sector_selects & PROTECT)) ? flash_seq_pkg::PROT_YES : flash_seq_pkg::PROT_NO;
  wire [7:0] query_data = (qsel == flash_seq_pkg::QUERY_ID) ? flash_seq_pkg::DEVICE_ID :
    (qsel == flash_seq_pkg::QUERY_PROT) ? prot_byte : ARRAY_DATA;
  wire [7:0] next_rdata = (state == flash_seq_pkg::ST_QUERY && rd_sel) ? query_data : ARRAY_DATA;

  always_comb begin
    next_state = state;
    if (wr_rise) begin
      case (state)
        flash_seq_pkg::ST_READ, flash_seq_pkg::ST_QUERY: begin
          if (is_unl1 && state == flash_seq_pkg::ST_READ) next_state = flash_seq_pkg::ST_UNL1;
          else if (suspend_ok && state == flash_seq_pkg::ST_READ) next_state = flash_seq_pkg::ST_SUSPENDED;
          else if (one_sel && d == flash_seq_pkg::CMD_RESET) begin
            next_state = suspended ? flash_seq_pkg::ST_SUSPENDED : flash_seq_pkg::ST_READ;
          end
        end
        flash_seq_pkg::ST_UNL1: next_state = is_unl2 ? flash_seq_pkg::ST_UNL2 : flash_seq_pkg::ST_READ;
        flash_seq_pkg::ST_UNL2: begin
          if (at_555 && d == flash_seq_pkg::CMD_READ_ID) next_state = flash_seq_pkg::ST_QUERY;
          else if (at_555 && d == flash_seq_pkg::CMD_PROGRAM) next_state = flash_seq_pkg::ST_PROG_DATA;
          else if (at_555 && d == flash_seq_pkg::CMD_ERASE_SETUP && !suspended) next_state = flash_seq_pkg::ST_ERA_SETUP;
          else next_state = suspended ? flash_seq_pkg::ST_SUSPENDED : flash_seq_pkg::ST_READ;
        end
        flash_seq_pkg::ST_PROG_DATA: next_state = suspended ? flash_seq_pkg::ST_SUSPENDED : flash_seq_pkg::ST_READ;
        flash_seq_pkg::ST_ERA_SETUP: next_state = is_unl1 ? flash_seq_pkg::ST_ERA_UNL1 : flash_seq_pkg::ST_READ;
        flash_seq_pkg::ST_ERA_UNL1: next_state = is_unl2 ? flash_seq_pkg::ST_ERA_UNL2 : flash_seq_pkg::ST_READ;
        flash_seq_pkg::ST_ERA_UNL2: begin
          if (one_sel && d == flash_seq_pkg::CMD_SECTOR) next_state = flash_seq_pkg::ST_ERA_ACCUM;
          else next_state = flash_seq_pkg::ST_READ;
        end
        flash_seq_pkg::ST_ERA_ACCUM: begin
          if (one_sel && d == flash_seq_pkg::CMD_SECTOR) next_state = flash_seq_pkg::ST_ERA_ACCUM;
          else next_state = flash_seq_pkg::ST_READ;
        end
        flash_seq_pkg::ST_SUSPENDED: begin
          if (one_sel && d == flash_seq_pkg::CMD_RESUME) next_state = flash_seq_pkg::ST_READ;
          else if (is_unl1) next_state = flash_seq_pkg::ST_UNL1;
        end
        default: next_state = flash_seq_pkg::ST_READ;
      endcase
    end else if (in_seq && state != flash_seq_pkg::ST_ERA_ACCUM && timed_out) begin
      next_state = suspended ? flash_seq_pkg::ST_SUSPENDED : flash_seq_pkg::ST_READ;
    end else if (state == flash_seq_pkg::ST_ERA_ACCUM && timed_out) begin
      next_state = flash_seq_pkg::ST_READ;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_sync <= 3'h7;
      wr_level <= 1'b1;
    end else begin
      wr_sync <= {wr_sync[1:0], BUS.wr_n};
      if (wr_sync[2] == wr_sync[1]) wr_level <= wr_sync[2];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lat_addr <= 18'h00000;
      lat_sel <= 8'h00;
    end else if (wr_fall) begin
      lat_addr <= BUS.addr;
      lat_sel <= BUS.sector_selects;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= flash_seq_pkg::ST_READ;
      tmo_cnt <= '0;
    end else begin
      state <= next_state;
      if (wr_rise) tmo_cnt <= '0;
      else if (!timed_out) tmo_cnt <= tmo_cnt + 1'b1;
    end
  end

  // Commands; data write is decoded, the array sees it only via PROG_*
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PROG_START <= 1'b0;
      PROG_ADDR <= 18'h00000;
      PROG_DATA <= 8'h00;
      ERASE_START <= 1'b0;
      ERASE_SECTORS <= 8'h00;
      ERASE_SUSPEND <= 1'b0;
      ERASE_RESUME <= 1'b0;
      erase_acc <= 8'h00;
      erasing <= 1'b0;
      suspended <= 1'b0;
    end else begin
      PROG_START <= 1'b0;
      ERASE_START <= 1'b0;
      ERASE_SUSPEND <= 1'b0;
      ERASE_RESUME <= 1'b0;
      if (wr_rise && state == flash_seq_pkg::ST_PROG_DATA && one_sel && !sel_prot) begin
        PROG_START <= 1'b1;
        PROG_ADDR <= lat_addr;
        PROG_DATA <= d;
      end
      if (wr_rise && state == flash_seq_pkg::ST_ERA_UNL2 && one_sel && d == flash_seq_pkg::CMD_BULK) begin
        ERASE_START <= 1'b1;
        ERASE_SECTORS <= flash_seq_pkg::ALL_SECTORS;
      end
      if (wr_rise && next_state == flash_seq_pkg::ST_ERA_ACCUM) erase_acc <= erase_acc | lat_sel;
      if (state == flash_seq_pkg::ST_ERA_ACCUM && next_state != flash_seq_pkg::ST_ERA_ACCUM
          && next_state != flash_seq_pkg::ST_SUSPENDED) begin
        ERASE_START <= 1'b1;
        ERASE_SECTORS <= erase_acc;
        erase_acc <= 8'h00;
        erasing <= 1'b1;
      end
      if (erasing && !ALGO_BUSY && !ERASE_START && !suspended) erasing <= 1'b0;
      if (wr_rise && suspend_ok && state == flash_seq_pkg::ST_READ) begin
        ERASE_SUSPEND <= 1'b1;
        suspended <= 1'b1;
      end
      if (wr_rise && state == flash_seq_pkg::ST_SUSPENDED && next_state == flash_seq_pkg::ST_READ) begin
        ERASE_RESUME <= 1'b1;
        suspended <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      err <= 1'b0;
      rdata <= 8'h00;
      PROT_REG <= 8'h00;
    end else begin
      if (ALGO_ERROR) err <= 1'b1;
      else if (wr_rise && one_sel && d == flash_seq_pkg::CMD_RESET) err <= 1'b0;
      rdata <= next_rdata;
      PROT_REG <= PROTECT;
    end
  end

  assign BUS.rdata = rdata;
  assign BUS.ready_busy_pin = ~(ALGO_BUSY | PROG_START | ERASE_START) | suspended;
  assign BUS.error_flag_bit = err;
endmodule : flash_instruction_sequence_decoder

// ==== src/flash_sequence_host.sv ====
`timescale 1ns/1ps
module flash_sequence_host (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Processor bus
  flash_bus_if.host BUS,
  // User commands
  input wire logic REQ_WRITE,
  input wire logic REQ_READ,
  input wire logic [17:0] REQ_ADDR,
  input wire logic [7:0] REQ_DATA,
  input wire logic [7:0] REQ_SEL,
  output logic REQ_DONE,
  output logic [7:0] RD_DATA,
  output logic READY,
  output logic ERROR
);
  // One bus cycle: setup, strobe low, hold; each phase a few clocks
  localparam logic [3:0] PHASE_CYC = 4'h8;
  logic [1:0] phase;
  logic [3:0] cnt;
  logic is_rd;
  logic [17:0] addr;
  logic [7:0] wdata;
  logic [7:0] sel;
  logic wr_n;
  logic rd_n;
  logic [2:0] rb_sync;
  logic [2:0] er_sync;
  wire idle = phase == 2'h0;
  wire cnt_end = cnt == PHASE_CYC;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase <= 2'h0;
      cnt <= 4'h0;
      is_rd <= 1'b0;
      addr <= 18'h00000;
      wdata <= 8'h00;
      sel <= 8'h00;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      REQ_DONE <= 1'b0;
      RD_DATA <= 8'h00;
    end else begin
      REQ_DONE <= 1'b0;
      cnt <= cnt_end ? 4'h0 : cnt + 4'h1;
      if (idle) begin
        cnt <= 4'h0;
        if (REQ_WRITE || REQ_READ) begin
          phase <= 2'h1;
          is_rd <= REQ_READ & ~REQ_WRITE;
          addr <= REQ_ADDR;
          wdata <= REQ_DATA;
          sel <= REQ_SEL;
        end
      end else if (cnt_end) begin
        case (phase)
          2'h1: begin
            phase <= 2'h2;
            wr_n <= is_rd;
            rd_n <= ~is_rd;
          end
          2'h2: begin
            phase <= 2'h3;
            if (is_rd) RD_DATA <= BUS.rdata;
            wr_n <= 1'b1;
            rd_n <= 1'b1;
          end
          default: begin
            phase <= 2'h0;
            sel <= 8'h00;
            REQ_DONE <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rb_sync <= 3'h0;
      er_sync <= 3'h0;
      READY <= 1'b0;
      ERROR <= 1'b0;
    end else begin
      rb_sync <= {rb_sync[1:0], BUS.ready_busy_pin};
      er_sync <= {er_sync[1:0], BUS.error_flag_bit};
      if (rb_sync[2] == rb_sync[1]) READY <= rb_sync[2];
      if (er_sync[2] == er_sync[1]) ERROR <= er_sync[2];
    end
  end

  // Sequences ..are composed by the user
  assign BUS.addr = addr;
  assign BUS.wdata = wdata;
  assign BUS.wr_n = wr_n;
  assign BUS.rd_n = rd_n;
  assign BUS.sector_selects = sel;
endmodule : flash_sequence_host

// ==== test/flash_seq_assertions.sv ====
`timescale 1ns/1ps
module flash_seq_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Processor bus
  input wire logic [7:0] wdata,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [7:0] sector_selects,
  input wire logic ready_busy_pin,
  input wire logic error_flag_bit,
  // Array side
  input wire logic [7:0] PROTECT,
  input wire logic PROG_START,
  input wire logic ERASE_START,
  input wire logic ERASE_SUSPEND,
  input wire logic ERASE_RESUME,
  input wire logic [7:0] PROT_REG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  AST_SEL_ONE: assert property ((!wr_n || !rd_n) |-> $onehot(sector_selects))
    else $error("bus cycle without exactly one sector select");
  AST_PROG_ONE: assert property (PROG_START |=> !PROG_START)
    else $error("program start longer than one cycle");
  AST_CMD_AFTER_RISE: assert property ((PROG_START || ERASE_SUSPEND || ERASE_RESUME) |-> wr_n && $past(wr_n, 2))
    else $error("command issued before write strobe rose");
  AST_ERASE_ONE: assert property (ERASE_START |=> !ERASE_START)
    else $error("erase start longer than one cycle");
  AST_SUSP_ALONE: assert property (ERASE_SUSPEND |-> !ERASE_RESUME ##1 !ERASE_SUSPEND)
    else $error("suspend pulse malformed");
  AST_BUSY: assert property ((PROG_START || ERASE_START) |=> !ready_busy_pin)
    else $error("ready shown while algorithm runs");
  AST_ERR_CLEAR: assert property ($fell(error_flag_bit) |-> wdata == flash_seq_pkg::CMD_RESET)
    else $error("error flag cleared without reset command");
  AST_PROT_REG: assert property (!$past(SYS_RST) |-> PROT_REG == $past(PROTECT))
    else $error("protection register does not follow protect inputs");
  COV_PROG: cover property (PROG_START);
  COV_ERASE: cover property (ERASE_START);
  COV_SUSP: cover property (ERASE_SUSPEND ##[1:300] ERASE_RESUME);
endmodule : flash_seq_assertions

// ==== test/flash_instruction_sequence_decoder_bench.sv ====
`timescale 1ns/1ps
module flash_instruction_sequence_decoder_bench;
  localparam int TMO = 50;
  logic CLK = 0;
  logic SYS_RST = 1;
  logic req_write = 0, req_read = 0, algo_error = 0, rd_pending = 0, held = 0;
  logic req_done, ready, error, prog_start, erase_start, erase_suspend, erase_resume;
  logic [17:0] req_addr = '0, prog_addr, a;
  logic [7:0] req_data = '0, req_sel = '0, protect = '0, array_data = '0, rd_data, prog_data, erase_sectors, prot_reg, d;
  int fails = 0, n_tests = 0, busy_cnt = 0;
  logic [2:0] q_kind[$];
  logic [25:0] q_val[$];
  wire algo_busy = busy_cnt != 0;
  flash_bus_if bus ();
  flash_instruction_sequence_decoder #(.TMO_CYC(TMO)) u_flash_instruction_sequence_decoder (.CLK(CLK),
    .SYS_RST(SYS_RST), .BUS(bus.device), .PROTECT(protect), .ARRAY_DATA(array_data), .ALGO_BUSY(algo_busy),
    .ALGO_ERROR(algo_error), .PROG_START(prog_start), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
    .ERASE_START(erase_start), .ERASE_SECTORS(erase_sectors), .ERASE_SUSPEND(erase_suspend),
    .ERASE_RESUME(erase_resume), .PROT_REG(prot_reg));
  flash_sequence_host u_flash_sequence_host (.CLK(CLK), .SYS_RST(SYS_RST), .BUS(bus.host), .REQ_WRITE(req_write),
    .REQ_READ(req_read), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .REQ_SEL(req_sel), .REQ_DONE(req_done),
    .RD_DATA(rd_data), .READY(ready), .ERROR(error));
  flash_seq_assertions u_flash_seq_assertions (.CLK(CLK), .SYS_RST(SYS_RST), .wdata(bus.wdata), .wr_n(bus.wr_n),
    .rd_n(bus.rd_n), .sector_selects(bus.sector_selects), .ready_busy_pin(bus.ready_busy_pin),
    .error_flag_bit(bus.error_flag_bit), .PROTECT(protect), .PROG_START(prog_start), .ERASE_START(erase_start),
    .ERASE_SUSPEND(erase_suspend), .ERASE_RESUME(erase_resume), .PROT_REG(prot_reg));
  initial forever #5 CLK = ~CLK;
  // Algorithm stand-in; the count freezes while erase is suspended
  always @(posedge CLK) begin
    if (prog_start) busy_cnt <= 20;
    else if (erase_start) busy_cnt <= 150;
    else if (busy_cnt != 0 && !held) busy_cnt <= busy_cnt - 1;
    if (erase_suspend) held <= 1;
    if (erase_resume) held <= 0;
  end
  always @(posedge CLK) begin
    if (prog_start) cmp_pulse(3'd1, {prog_addr, prog_data});
    if (erase_start) cmp_pulse(3'd2, {18'h0, erase_sectors});
    if (erase_suspend) cmp_pulse(3'd3, '0);
    if (erase_resume) cmp_pulse(3'd4, '0);
    if (req_done && rd_pending) cmp_pulse(3'd5, {18'h0, rd_data});
  end
  task automatic cmp_pulse(input logic [2:0] k, input logic [25:0] v);
    logic [2:0] ek;
    logic [25:0] ev;
    ek = q_kind.size() ? q_kind.pop_front() : 3'd0;
    ev = q_val.size() ? q_val.pop_front() : 26'h0;
    n_tests++;
    if (ek !== k || ev !== v) begin
      fails++;
      $display("wrong value at %0t: result %0d %h, expected %0d %h", $time, k, v, ek, ev);
    end
  endtask : cmp_pulse
  task automatic cmp_level(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: level %b, expected %b", $time, got, exp);
    end
  endtask : cmp_level
  task automatic expect_ev(input logic [2:0] k, input logic [25:0] v);
    q_kind.push_back(k);
    q_val.push_back(v);
  endtask : expect_ev
  task automatic xfer(input logic rd, input logic [17:0] ad, input logic [7:0] dt);
    req_addr <= ad;
    req_data <= dt;
    req_sel <= 8'h01 << ad[16:14];
    req_write <= !rd;
    req_read <= rd;
    rd_pending <= rd;
    @(posedge CLK);
    req_write <= 0;
    req_read <= 0;
    repeat (100) begin
      @(posedge CLK);
      if (req_done === 1'b1) break;
    end
    if (req_done !== 1'b1) cmp_level(1'b0, 1'b1);
  endtask : xfer
  // Upper address bits random: decoding must ignore them
  task automatic seq(input logic [7:0] cmd);
    xfer(1'b0, {6'($urandom), flash_seq_pkg::ADDR_UNLOCK1}, flash_seq_pkg::CMD_UNLOCK1);
    xfer(1'b0, {6'($urandom), flash_seq_pkg::ADDR_UNLOCK2}, flash_seq_pkg::CMD_UNLOCK2);
    xfer(1'b0, {6'($urandom), flash_seq_pkg::ADDR_UNLOCK1}, cmd);
  endtask : seq
  task automatic chk_read();
    expect_ev(3'd5, {18'h0, array_data});
    xfer(1'b1, 18'($urandom), 8'h00);
  endtask : chk_read
  task automatic wait_ready();
    repeat (400) begin
      @(posedge CLK);
      if (ready === 1'b1 && !algo_busy) break;
    end
    repeat (4) @(posedge CLK);
  endtask : wait_ready
  task automatic finish_test();
    if (q_kind.size() != 0) fails++;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    #200us;
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    void'($urandom(32'h59f1));
    protect <= (8'($urandom) | 8'h80) & 8'hda;
    array_data <= 8'($urandom);
    repeat (4) @(posedge CLK);
    SYS_RST <= 0;
    // Ready crosses three sampler stages in the host
    repeat (6) @(posedge CLK);
    cmp_level(ready, 1'b1);
    for (int s = 0; s < 8; s++) begin
      cmp_level(prot_reg[s], protect[s]);
    end
    chk_read();
    xfer(1'b0, 18'h04000, flash_seq_pkg::CMD_SUSPEND);
    xfer(1'b0, 18'h04000, flash_seq_pkg::CMD_RESUME);
    $display("read array and refused single commands done");
    seq(flash_seq_pkg::CMD_READ_ID);
    expect_ev(3'd5, {18'h0, flash_seq_pkg::DEVICE_ID});
    xfer(1'b1, 18'h00001, 8'h00);
    for (int s = 0; s < 8; s++) begin
      expect_ev(3'd5, {25'h0, protect[s]});
      xfer(1'b1, {1'b0, 3'(s), 14'h0002}, 8'h00);
    end
    xfer(1'b0, 18'h08000, flash_seq_pkg::CMD_RESET);
    chk_read();
    $display("identifier and protection done");
    d = 8'($urandom);
    a = {4'h0, 14'($urandom)};
    seq(flash_seq_pkg::CMD_PROGRAM);
    expect_ev(3'd1, {a, d});
    xfer(1'b0, a, d);
    wait_ready();
    seq(flash_seq_pkg::CMD_PROGRAM);
    xfer(1'b0, 18'h1c010, d);
    chk_read();
    $display("program done");
    seq(8'h77);
    xfer(1'b0, {6'h0, flash_seq_pkg::ADDR_UNLOCK1}, flash_seq_pkg::CMD_PROGRAM);
    xfer(1'b0, a, d);
    xfer(1'b0, {6'h0, flash_seq_pkg::ADDR_UNLOCK1}, flash_seq_pkg::CMD_UNLOCK1);
    repeat (TMO + 30) @(posedge CLK);
    xfer(1'b0, {6'h0, flash_seq_pkg::ADDR_UNLOCK2}, flash_seq_pkg::CMD_UNLOCK2);
    xfer(1'b0, {6'h0, flash_seq_pkg::ADDR_UNLOCK1}, flash_seq_pkg::CMD_PROGRAM);
    xfer(1'b0, a, d);
    chk_read();
    $display("abort cases done");
    seq(flash_seq_pkg::CMD_ERASE_SETUP);
    expect_ev(3'd2, {18'h0, flash_seq_pkg::ALL_SECTORS});
    seq(flash_seq_pkg::CMD_BULK);
    wait_ready();
    seq(flash_seq_pkg::CMD_ERASE_SETUP);
    xfer(1'b0, {6'h0, flash_seq_pkg::ADDR_UNLOCK1}, flash_seq_pkg::CMD_UNLOCK1);
    xfer(1'b0, {6'h0, flash_seq_pkg::ADDR_UNLOCK2}, flash_seq_pkg::CMD_UNLOCK2);
    expect_ev(3'd2, 26'h24);
    xfer(1'b0, 18'h08123, flash_seq_pkg::CMD_SECTOR);
    xfer(1'b0, 18'h14321, flash_seq_pkg::CMD_SECTOR);
    repeat (TMO + 40) begin
      @(posedge CLK);
      if (algo_busy) break;
    end
    expect_ev(3'd3, '0);
    xfer(1'b0, 18'h08000, flash_seq_pkg::CMD_SUSPEND);
    expect_ev(3'd4, '0);
    xfer(1'b0, 18'h08000, flash_seq_pkg::CMD_RESUME);
    wait_ready();
    $display("erase cases done");
    algo_error <= 1;
    repeat (3) @(posedge CLK);
    algo_error <= 0;
    repeat (8) @(posedge CLK);
    cmp_level(error, 1'b1);
    xfer(1'b0, 18'h0c000, flash_seq_pkg::CMD_RESET);
    repeat (8) @(posedge CLK);
    cmp_level(error, 1'b0);
    $display("error flag done");
    finish_test();
  end
endmodule : flash_instruction_sequence_decoder_bench
